// *** common/asp_link_if.sv ***
// Interface between port sequencer and serial shifter
`timescale 1ns/1ps
interface asp_link_if;
    logic                       clear;
    logic                       load;
    logic [asp_pkg::WORD_W-1:0] tx_word;
    logic [asp_pkg::CNT_W-1:0]  len;
    logic                       done;
    logic [asp_pkg::WORD_W-1:0] rx_word;

    modport main  (output clear, load, tx_word, len,
                   input  done, rx_word);
    modport shift (input  clear, load, tx_word, len,
                   output done, rx_word);
endinterface

// *** common/asp_pkg.sv ***
// Package of constants for the converter serial port block
package asp_pkg;
    // ------------------------------------------------------------
    // Word widths
    // ------------------------------------------------------------
    localparam int unsigned BYTE_W    = 8;
    localparam int unsigned WORD_W    = 16;
    localparam int unsigned CNT_W     = 5;
    localparam logic [4:0]  LEN_BYTE  = 5'h08;
    localparam logic [4:0]  LEN_WORD  = 5'h10;
    // ------------------------------------------------------------
    // Selection field and read/write bit of the communication register
    // ------------------------------------------------------------
    localparam int unsigned RS_LSB    = 4;
    localparam int unsigned RS_MSB    = 6;
    localparam int unsigned RW_BIT    = 3;
    localparam logic [2:0]  RS_COMM   = 3'h0;
    localparam logic [2:0]  RS_SETUP  = 3'h1;
    localparam logic [2:0]  RS_CLOCK  = 3'h2;
    localparam logic [2:0]  RS_DATA   = 3'h3;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  COMM_RST  = 8'h00;
    localparam logic [7:0]  SETUP_RST = 8'h00;
    localparam logic [7:0]  CLOCK_RST = 8'h00;
    localparam logic [15:0] DATA_RST  = 16'h0000;
    // ------------------------------------------------------------
    // Timing: ready held high before a data update
    // ------------------------------------------------------------
    localparam int unsigned CLK_NS       = 100;
    localparam int unsigned UPD_HOLD_NS  = 50000;
    localparam int unsigned UPD_HOLD_CYC = UPD_HOLD_NS / CLK_NS;
    localparam int unsigned HOLD_W       = 10;
    // ------------------------------------------------------------
    // Port sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ASP_ST_COMM,
        ASP_ST_WRITE,
        ASP_ST_READ
    } asp_state_t;
endpackage

// *** testbench/asp_host_model.sv ***
// Serial host model: select, serial clock and input data
`timescale 1ns/1ps
module asp_host_model (
    // Clock
    input  wire logic clk_sys,
    // Serial pins
    output logic      cs_n,
    output logic      sclk,
    output logic      din,
    input  wire logic dout
);
    logic three_wire;
    initial begin
        cs_n       = 1'b1;
        sclk       = 1'b1;
        din        = 1'b1;
        three_wire = 1'b0;
    end
    // Clock only within bursts, idle high; keep holds select low
    task automatic xfer(input logic [15:0] tx, input int n,
                        input logic keep, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk_sys);
        cs_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int i = n - 1; i >= 0; i--) begin
            sclk <= 1'b0;
            din  <= tx[i];
            repeat (4) @(posedge clk_sys);
            sclk <= 1'b1;
            repeat (4) @(posedge clk_sys);
            rx = {rx[14:0], dout};
        end
        din  <= ~tx[0];
        cs_n <= !(keep || three_wire);
        repeat (4) @(posedge clk_sys);
    endtask
endmodule // asp_host_model

// *** testbench/asp_serial_port_props.sv ***
// Checker of serial port and ready timing
`timescale 1ns/1ps
module asp_serial_port_props (
    // Clock and reset
    input wire logic                        clk_sys,
    input wire logic                        rst,
    // Pins
    input wire logic                        reset_n,
    input wire logic                        cs_n,
    input wire logic                        sclk,
    input wire logic                        dout,
    input wire logic                        conversion_ready_n,
    // Core side
    input wire logic                        result_valid,
    input wire logic                        cal_done,
    input wire logic [asp_pkg::BYTE_W-1:0]  setup_reg,
    input wire logic [asp_pkg::BYTE_W-1:0]  clock_reg,
    input wire logic                        core_reset
);
    logic [9:0] hold_ff;
    logic [3:0] quiet_ff;
    logic       sclk_ff;
    logic       cs_ff;
    logic       rn_ff;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Cycles since last result; cal or pin reset cancels the hold
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_ff <= 10'h000;
        end else if (!reset_n || cal_done) begin
            hold_ff <= 10'h000;
        end else if (result_valid) begin
            hold_ff <= 10'h001;
        end else if (hold_ff != 10'h000 && hold_ff < 10'h1f4) begin
            hold_ff <= hold_ff + 10'h001;
        end
    end
    // Cycles since any sclk, cs_n or reset_n edge, saturating
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            quiet_ff <= 4'hf;
        end else if (sclk != sclk_ff || cs_n != cs_ff || reset_n != rn_ff) begin
            quiet_ff <= 4'h0;
        end else if (quiet_ff != 4'hf) begin
            quiet_ff <= quiet_ff + 4'h1;
        end
    end
    always_ff @(posedge clk_sys) begin
        sclk_ff <= sclk;
        cs_ff   <= cs_n;
        rn_ff   <= reset_n;
    end
    rdy_rise_a: assert property (
        result_valid |-> ##[1:2] conversion_ready_n)
        else $error("ready not raised after result");
    hold_high_a: assert property (
        (hold_ff >= 10'h003 && hold_ff <= 10'h1f2) |-> conversion_ready_n)
        else $error("ready dropped during update hold");
    upd_low_a: assert property (
        hold_ff == 10'h1f3 |-> ##[1:4] !conversion_ready_n)
        else $error("ready not low after update");
    cal_low_a: assert property (
        cal_done && !result_valid && reset_n
        && (hold_ff == 10'h000 || hold_ff == 10'h1f4)
        |-> ##[1:2] !conversion_ready_n)
        else $error("ready not low after calibration");
    fall_cause_a: assert property (
        $fell(conversion_ready_n) |-> hold_ff >= 10'h1f3
        || $past(cal_done) || $past(cal_done, 2))
        else $error("ready fell without update or calibration");
    pin_reset_a: assert property (
        !reset_n [*5] |-> core_reset && conversion_ready_n
        && setup_reg == asp_pkg::SETUP_RST && clock_reg == asp_pkg::CLOCK_RST)
        else $error("pin reset did not clear state");
    pin_release_a: assert property (
        $rose(reset_n) |-> ##[2:5] !core_reset)
        else $error("core reset stuck after pin release");
    dout_edge_a: assert property (
        $changed(dout) && !core_reset && !$past(core_reset)
        |-> quiet_ff <= 4'h6)
        else $error("serial output moved away from clock edge");
    reg_edge_a: assert property (
        $changed(setup_reg) && !core_reset && !$past(core_reset)
        |-> quiet_ff <= 4'h7)
        else $error("setup register moved without serial traffic");
endmodule // asp_serial_port_props

bind asp_serial_port asp_serial_port_props chk_u (
    .clk_sys(clk_sys), .rst(rst), .reset_n(reset_n), .cs_n(cs_n),
    .sclk(sclk), .dout(dout), .conversion_ready_n(conversion_ready_n),
    .result_valid(result_valid), .cal_done(cal_done),
    .setup_reg(setup_reg), .clock_reg(clock_reg), .core_reset(core_reset)
);

// *** testbench/asp_serial_port_tb_top.sv ***
// Testbench of the converter serial port
`timescale 1ns/1ps
module asp_serial_port_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        reset_n = 1'b1;
    logic        cs_n;
    logic        sclk;
    logic        din;
    logic        dout;
    logic        conversion_ready_n;
    logic        result_valid = 1'b0;
    logic [15:0] result_word = 16'h0000;
    logic        cal_done = 1'b0;
    logic [7:0]  setup_reg;
    logic [7:0]  clock_reg;
    logic [7:0]  comm_reg;
    logic        core_reset;
    int          err_total = 0;
    int          checks_done = 0;

    always #50 clk_sys = ~clk_sys;

    asp_serial_port dut_u (.clk_sys(clk_sys), .rst(rst), .reset_n(reset_n),
        .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
        .conversion_ready_n(conversion_ready_n), .result_valid(result_valid),
        .result_word(result_word), .cal_done(cal_done),
        .setup_reg(setup_reg), .clock_reg(clock_reg), .comm_reg(comm_reg),
        .core_reset(core_reset));
    asp_host_model host_u (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk),
        .din(din), .dout(dout));

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Comm byte then one write byte or read byte or word, select held
    task automatic access(input logic [2:0] sel, input logic rd,
        input logic [15:0] val, input int n, output logic [15:0] got);
        host_u.xfer({8'h00, 1'b0, sel, rd, 3'h0}, 8, 1'b1, got);
        host_u.xfer(val, n, 1'b0, got);
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic t_regs();
        logic [15:0] got;
        access(asp_pkg::RS_SETUP, 1'b0, 16'h005a, 8, got);
        check("setup_reg", {8'h00, setup_reg}, 16'h005a);
        access(asp_pkg::RS_CLOCK, 1'b0, 16'h00a5, 8, got);
        check("clock_reg", {8'h00, clock_reg}, 16'h00a5);
        // Data takes no write byte: only the comm byte goes out
        host_u.xfer({8'h00, 1'b0, asp_pkg::RS_DATA, 1'b0, 3'h0}, 8, 1'b0, got);
        repeat (6) @(posedge clk_sys);
        check("regs_kept", {setup_reg, clock_reg}, 16'h5aa5);
        check("comm_data", {8'h00, comm_reg}, 16'h0030);
        access(asp_pkg::RS_SETUP, 1'b1, 16'h0000, 8, got);
        check("setup_read", got, 16'h005a);
        access(asp_pkg::RS_CLOCK, 1'b1, 16'h0000, 8, got);
        check("clock_read", got, 16'h00a5);
        access(asp_pkg::RS_COMM, 1'b1, 16'h0000, 8, got);
        check("comm_read", got, 16'h0008);
        check("comm_reg", {8'h00, comm_reg}, 16'h0008);
    endtask

    // Two unread results, each held out until ready falls, then one full read
    task automatic t_result();
        logic [15:0] got;
        for (int k = 0; k < 2; k++) begin
            result_word  <= (k == 0) ? 16'hc3a5 : 16'h3c5a;
            result_valid <= 1'b1;
            @(posedge clk_sys);
            result_valid <= 1'b0;
            repeat (3) @(posedge clk_sys);
            check("ready_hold", conversion_ready_n, 16'h0001);
            repeat (490) @(posedge clk_sys);
            check("ready_late", conversion_ready_n, 16'h0001);
            repeat (12) @(posedge clk_sys);
            check("ready_new", conversion_ready_n, 16'h0000);
        end
        access(asp_pkg::RS_DATA, 1'b1, 16'h0000, 16, got);
        check("data_read", got, 16'h3c5a);
        check("ready_read", conversion_ready_n, 16'h0001);
    endtask

    task automatic t_cal();
        cal_done <= 1'b1;
        @(posedge clk_sys);
        cal_done <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check("ready_cal", conversion_ready_n, 16'h0000);
    endtask

    // Aborted partial word, then select tied low with bursts
    task automatic t_wire();
        logic [15:0] got;
        host_u.xfer(16'h0005, 3, 1'b0, got);
        access(asp_pkg::RS_SETUP, 1'b0, 16'h0081, 8, got);
        check("setup_abort", {8'h00, setup_reg}, 16'h0081);
        host_u.three_wire = 1'b1;
        access(asp_pkg::RS_CLOCK, 1'b0, 16'h003c, 8, got);
        check("clock_3wire", {8'h00, clock_reg}, 16'h003c);
        host_u.three_wire = 1'b0;
    endtask

    task automatic t_pin();
        reset_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check("pin_regs", {setup_reg, clock_reg}, 16'h0000);
        check("pin_out", {conversion_ready_n, core_reset}, 16'h0003);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check("core_free", {15'h0000, core_reset}, 16'h0000);
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check("rst_regs", {setup_reg, clock_reg}, 16'h0000);
        check("rst_out", {conversion_ready_n, core_reset}, 16'h0002);
        t_regs();
        t_result();
        t_cal();
        t_wire();
        t_pin();
        close_out();
    end

    // Whole run is near 2400 cycles; cut off well beyond
    initial begin
        #1_500_000;
        err_total++;
        close_out();
    end
endmodule // asp_serial_port_tb_top

// *** verilog/asp_serial_port.sv ***
// Converter serial port with conversion-ready signalling
`timescale 1ns/1ps
module asp_serial_port (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // Device reset pin
    input  wire logic                       reset_n,
    // Serial pins
    input  wire logic                       cs_n,
    input  wire logic                       sclk,
    input  wire logic                       din,
    output logic                            dout,
    output logic                            conversion_ready_n,
    // Filter and calibration side
    input  wire logic                       result_valid,
    input  wire logic [asp_pkg::WORD_W-1:0] result_word,
    input  wire logic                       cal_done,
    // Register contents and pin reset to the converter core
    output logic [asp_pkg::BYTE_W-1:0]      setup_reg,
    output logic [asp_pkg::BYTE_W-1:0]      clock_reg,
    output logic [asp_pkg::BYTE_W-1:0]      comm_reg,
    output logic                            core_reset
);
    // ------------------------------------------------------------
    // Reset pin synchroniser
    // ------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_sync_ff;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= ~reset_n;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Filter, modulator and coefficients reset through this output
    assign core_reset = rst_sync_ff;

    // ------------------------------------------------------------
    // Shifter
    // ------------------------------------------------------------
    asp_link_if lnk ();

    asp_shifter u_shifter (
        .clk_sys (clk_sys),
        .rst     (rst),
        .cs_n    (cs_n),
        .sclk    (sclk),
        .din     (din),
        .dout    (dout),
        .lnk     (lnk)
    );

    // ------------------------------------------------------------
    // Selection decode
    // ------------------------------------------------------------
    function automatic logic [2:0] sel_of(input logic [7:0] c);
        sel_of = c[asp_pkg::RS_MSB:asp_pkg::RS_LSB];
    endfunction

    asp_pkg::asp_state_t        state_ff;
    logic [7:0]                 comm_ff;
    logic [7:0]                 setup_ff;
    logic [7:0]                 clock_ff;
    logic [asp_pkg::WORD_W-1:0] data_ff;
    logic                       load_ff;
    logic [asp_pkg::WORD_W-1:0] tx_word_ff;
    logic [7:0]                 rx_byte;
    logic                       data_read_done;

    assign rx_byte = lnk.rx_word[7:0];

    // Read source chosen by the selection bits
    function automatic logic [asp_pkg::WORD_W-1:0] rd_src(
        input logic [2:0]  s,
        input logic [7:0]  cm,
        input logic [7:0]  su,
        input logic [7:0]  ck,
        input logic [15:0] dt
    );
        case (s)
            asp_pkg::RS_SETUP: rd_src = {su, 8'h00};
            asp_pkg::RS_CLOCK: rd_src = {ck, 8'h00};
            asp_pkg::RS_DATA:  rd_src = dt;
            default:           rd_src = {cm, 8'h00};
        endcase
    endfunction

    // ------------------------------------------------------------
    // Port sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff   <= asp_pkg::ASP_ST_COMM;
            load_ff    <= 1'b0;
            tx_word_ff <= asp_pkg::DATA_RST;
        end else if (rst_sync_ff) begin
            state_ff   <= asp_pkg::ASP_ST_COMM;
            load_ff    <= 1'b0;
            tx_word_ff <= asp_pkg::DATA_RST;
        end else begin
            load_ff <= 1'b0;
            if (lnk.done) begin
                case (state_ff)
                    asp_pkg::ASP_ST_COMM: begin
                        if (rx_byte[asp_pkg::RW_BIT]) begin
                            state_ff   <= asp_pkg::ASP_ST_READ;
                            tx_word_ff <= rd_src(sel_of(rx_byte), rx_byte,
                                setup_ff, clock_ff, data_ff);
                            load_ff    <= 1'b1;
                        end else if (sel_of(rx_byte) == asp_pkg::RS_DATA) begin
                            // Data register is read-only
                            state_ff <= asp_pkg::ASP_ST_COMM;
                        end else begin
                            state_ff <= asp_pkg::ASP_ST_WRITE;
                        end
                    end
                    default: begin
                        state_ff <= asp_pkg::ASP_ST_COMM;
                    end
                endcase
            end
        end
    end

    assign data_read_done = lnk.done && (state_ff == asp_pkg::ASP_ST_READ)
                            && (sel_of(comm_ff) == asp_pkg::RS_DATA);

    assign lnk.clear   = rst_sync_ff;
    assign lnk.load    = load_ff;
    assign lnk.tx_word = tx_word_ff;
    assign lnk.len     = (state_ff == asp_pkg::ASP_ST_READ &&
                          sel_of(comm_ff) == asp_pkg::RS_DATA)
                         ? asp_pkg::LEN_WORD : asp_pkg::LEN_BYTE;

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    logic wr_hit;
    assign wr_hit = lnk.done && (state_ff == asp_pkg::ASP_ST_WRITE);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            comm_ff  <= asp_pkg::COMM_RST;
            setup_ff <= asp_pkg::SETUP_RST;
            clock_ff <= asp_pkg::CLOCK_RST;
        end else if (rst_sync_ff) begin
            comm_ff  <= asp_pkg::COMM_RST;
            setup_ff <= asp_pkg::SETUP_RST;
            clock_ff <= asp_pkg::CLOCK_RST;
        end else if (lnk.done && state_ff == asp_pkg::ASP_ST_COMM) begin
            comm_ff <= rx_byte;
        end else if (wr_hit) begin
            case (sel_of(comm_ff))
                asp_pkg::RS_SETUP: setup_ff <= rx_byte;
                asp_pkg::RS_CLOCK: clock_ff <= rx_byte;
                default:           comm_ff  <= rx_byte;
            endcase
        end
    end

    assign setup_reg = setup_ff;
    assign clock_reg = clock_ff;
    assign comm_reg  = comm_ff;

    // ------------------------------------------------------------
    // Result update and ready flag
    // ------------------------------------------------------------
    // Each result waits the full hold so the host sees a fixed gap
    logic                       pend_ff;
    logic [asp_pkg::WORD_W-1:0] pend_word_ff;
    logic [asp_pkg::HOLD_W-1:0] hold_ff;
    logic                       ready_n_ff;
    logic                       upd;

    assign upd = pend_ff &&
        (hold_ff == asp_pkg::HOLD_W'(asp_pkg::UPD_HOLD_CYC - 1));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_ff      <= 1'b0;
            pend_word_ff <= asp_pkg::DATA_RST;
            hold_ff      <= '0;
        end else if (rst_sync_ff) begin
            pend_ff      <= 1'b0;
            hold_ff      <= '0;
        end else if (result_valid) begin
            pend_ff      <= 1'b1;
            pend_word_ff <= result_word;
            hold_ff      <= '0;
        end else if (upd) begin
            pend_ff      <= 1'b0;
            hold_ff      <= '0;
        end else if (pend_ff) begin
            hold_ff      <= hold_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            data_ff <= asp_pkg::DATA_RST;
        end else if (rst_sync_ff) begin
            data_ff <= asp_pkg::DATA_RST;
        end else if (upd) begin
            // Host keeps off the port while ready is high
            data_ff <= pend_word_ff;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ready_n_ff <= 1'b1;
        end else if (rst_sync_ff) begin
            ready_n_ff <= 1'b1;
        end else if (upd || cal_done) begin
            ready_n_ff <= 1'b0;
        end else if (result_valid || data_read_done) begin
            ready_n_ff <= 1'b1;
        end
    end

    assign conversion_ready_n = ready_n_ff;
endmodule // asp_serial_port

// *** verilog/asp_shifter.sv ***
// Serial shifter: pin synchronisers, edge finding, in and out shifting
`timescale 1ns/1ps
module asp_shifter (
    // Clock and reset
    input  wire logic   clk_sys,
    input  wire logic   rst,
    // Serial pins
    input  wire logic   cs_n,
    input  wire logic   sclk,
    input  wire logic   din,
    output logic        dout,
    // Sequencer side
    asp_link_if.shift   lnk
);
    // ------------------------------------------------------------
    // Two-stage synchronisers
    // ------------------------------------------------------------
    logic [2:0] meta_ff;
    logic [2:0] sync_ff;
    logic       sclk_d_ff;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_ff   <= 3'h7;
            sync_ff   <= 3'h7;
            sclk_d_ff <= 1'b1;
        end else begin
            meta_ff   <= {cs_n, sclk, din};
            sync_ff   <= meta_ff;
            sclk_d_ff <= sync_ff[1];
        end
    end

    logic cs_n_s;
    logic sclk_s;
    logic din_s;
    logic rise;
    logic fall;
    assign cs_n_s  = sync_ff[2];
    assign sclk_s  = sync_ff[1];
    assign din_s   = sync_ff[0];
    // Clock bursts of any length are fine: only edges count
    assign rise    = sclk_s & ~sclk_d_ff & ~cs_n_s;
    assign fall    = ~sclk_s & sclk_d_ff & ~cs_n_s;

    // ------------------------------------------------------------
    // Receive side: sample on rising edge, MSB first
    // ------------------------------------------------------------
    logic [asp_pkg::WORD_W-1:0] rx_sr_ff;
    logic [asp_pkg::CNT_W-1:0]  cnt_ff;
    logic                       done_ff;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_sr_ff <= asp_pkg::DATA_RST;
            cnt_ff   <= '0;
            done_ff  <= 1'b0;
        end else if (lnk.clear || cs_n_s || lnk.load) begin
            // Deselect drops a partial word; tied low it never fires
            cnt_ff   <= '0;
            done_ff  <= 1'b0;
        end else if (rise) begin
            rx_sr_ff <= {rx_sr_ff[asp_pkg::WORD_W-2:0], din_s};
            if (cnt_ff == lnk.len - 5'h01) begin
                cnt_ff  <= '0;
                done_ff <= 1'b1;
            end else begin
                cnt_ff  <= cnt_ff + 5'h01;
                done_ff <= 1'b0;
            end
        end else begin
            done_ff <= 1'b0;
        end
    end

    assign lnk.done    = done_ff;
    assign lnk.rx_word = rx_sr_ff;

    // ------------------------------------------------------------
    // Transmit side: next bit presented on falling edge
    // ------------------------------------------------------------
    logic [asp_pkg::WORD_W-1:0] tx_sr_ff;
    logic                       dout_ff;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_sr_ff <= asp_pkg::DATA_RST;
            dout_ff  <= 1'b0;
        end else if (lnk.clear) begin
            tx_sr_ff <= asp_pkg::DATA_RST;
            dout_ff  <= 1'b0;
        end else if (lnk.load) begin
            tx_sr_ff <= lnk.tx_word;
        end else if (fall) begin
            dout_ff  <= tx_sr_ff[asp_pkg::WORD_W-1];
            tx_sr_ff <= {tx_sr_ff[asp_pkg::WORD_W-2:0], 1'b0};
        end
    end

    assign dout = dout_ff;
endmodule // asp_shifter
